// ### hpw_cfg.svh
// Constants shared by both ends of the half-word host port.
// Assumes a single 50 MHz core clock and a synchronous active-low reset.
`ifndef HPW_CFG_SVH
`define HPW_CFG_SVH

// Value of the swap control word that turns the half-word swap on
`define HPW_SWAP_KEY 32'h0FFFFFFF
// Half select levels as seen on the bus
`define HPW_HALF_LO 1'b0
`define HPW_HALF_HI 1'b1
// Default doubleword address width (address bits 2 and up)
`define HPW_ADDR_W 8
// Default depth of the write buffer on the device side
`define HPW_FIFO_DEPTH 2
// Core clock period in ns
`define HPW_CLK_NS 20

`endif

// ### hpw_pkg.sv
// Types shared by both ends of the half-word host port.
// Assumes hpw_cfg.svh carries every number; this package carries types only.
package hpw_pkg;

  // Device end sequencing
  typedef enum logic [1:0] {
    HPW_DEV_IDLE,
    HPW_DEV_FETCH,
    HPW_DEV_ACK
  } hpw_dev_state_t;

  // Host end sequencing
  typedef enum logic [1:0] {
    HPW_HOST_IDLE,
    HPW_HOST_FIRST,
    HPW_HOST_SECOND
  } hpw_host_state_t;

endpackage

// ### hpw_if.sv
// Carrier between host end and device end of the 16-bit SRAM-like port.
// Assumes both ends share core_clk_i; the testbench supplies the clock.
`timescale 1ns/100ps
`default_nettype none
interface hpw_if #(
  parameter int AW = 8
);
  logic cs; // Access requested, held until ack
  logic we; // High for write, low for read
  logic [AW-1:0] dw_addr; // Doubleword address, bits 2 and up
  logic half_select_addr; // Address bit 1
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack; // One-cycle pulse, access finished

  modport host_mp (
    output cs, we, dw_addr, half_select_addr, wdata,
    input rdata, ack
  );
  modport dev_mp (
    input cs, we, dw_addr, half_select_addr, wdata,
    output rdata, ack
  );
endinterface
`default_nettype wire

// ### hpw_dev.sv
// Device end of the half-word host port: pairs 16-bit accesses into doublewords.
// Assumes a host that holds cs until ack and drives the bus from flops.
`timescale 1ns/100ps
`default_nettype none
`include "hpw_cfg.svh"
module hpw_dev #(
  parameter int AW = `HPW_ADDR_W,
  parameter int DEPTH = `HPW_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Host bus
  hpw_if.dev_mp bus,
  // Swap control word
  input wire logic [31:0] swap_ctrl_i,
  // Internal doubleword write stream
  output logic wr_valid_o,
  output logic [AW-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  input wire logic wr_ready_i,
  // Internal doubleword read port
  output logic rd_req_o,
  output logic [AW-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  hpw_pkg::hpw_dev_state_t state_q;
  logic ack_q;
  logic [15:0] rdata_q;
  logic wr_pend_q;
  logic wr_half_q;
  logic [15:0] stage_q;
  logic [AW-1:0] stage_addr_q;
  logic rd_pend_q;
  logic rd_half_q;
  logic [31:0] rd_latch_q;
  logic rd_req_q;
  logic [AW-1:0] rd_addr_q;
  logic [AW+31:0] mem_q [DEPTH];
  logic [PW-1:0] head_q;
  logic [PW-1:0] tail_q;
  logic [CW-1:0] count_q;

  // swap decode
  // Any word other than the key leaves the default mapping in force.
  wire swap_on = (swap_ctrl_i == `HPW_SWAP_KEY);
  // one mapping for all
  // Physical half: 0 means bytes 1:0, 1 means bytes 3:2.
  wire phys_half = bus.half_select_addr ^ swap_on;

  // Access decode; an access is not taken while its ack is still out
  wire take = bus.cs && !ack_q && (state_q == hpw_pkg::HPW_DEV_IDLE);
  wire wr_take = take && bus.we;
  wire rd_take = take && !bus.we;

  // Write buffer status; a full buffer stalls the host on the pairing half
  wire buf_full = (count_q == CW'(DEPTH));
  wire buf_empty = (count_q == '0);
  wire pop = !buf_empty && wr_ready_i;
  wire wr_pair = wr_pend_q && (phys_half != wr_half_q);
  wire wr_repeat = wr_pend_q && (phys_half == wr_half_q);
  wire wr_stall = wr_take && wr_pair && buf_full;
  wire push = wr_take && wr_pair && !buf_full;
  // low half in bits 15:0
  // Bits 15:0 are the word that leaves for the network first.
  wire [31:0] commit_word = phys_half ? {bus.wdata, stage_q} : {stage_q, bus.wdata};

  wire rd_pair = rd_pend_q && (rd_half_q != phys_half);
  wire rd_repeat = rd_pend_q && (rd_half_q == phys_half);
  wire [15:0] latch_half = phys_half ? rd_latch_q[31:16] : rd_latch_q[15:0];
  wire [15:0] fetch_half = phys_half ? rd_data_i[31:16] : rd_data_i[15:0];

  // Head of the buffer drives the internal write stream
  assign wr_valid_o = !buf_empty;
  assign wr_addr_o = mem_q[head_q][AW+31:32];
  assign wr_data_o = mem_q[head_q][31:0];
  assign rd_req_o = rd_req_q;
  assign rd_addr_o = rd_addr_q;
  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  // Access sequencer
  // The ack state gives the host one cycle to drop or change its request.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_q <= hpw_pkg::HPW_DEV_IDLE;
      ack_q <= 1'b0;
    end else begin
      unique case (state_q)
        hpw_pkg::HPW_DEV_IDLE: begin
          if (rd_take && !rd_pend_q) begin
            state_q <= hpw_pkg::HPW_DEV_FETCH;
          end else if (take && !wr_stall) begin
            ack_q <= 1'b1;
            state_q <= hpw_pkg::HPW_DEV_ACK;
          end
        end
        hpw_pkg::HPW_DEV_FETCH: begin
          if (rd_ack_i) begin
            ack_q <= 1'b1;
            state_q <= hpw_pkg::HPW_DEV_ACK;
          end
        end
        hpw_pkg::HPW_DEV_ACK: begin
          ack_q <= 1'b0;
          state_q <= hpw_pkg::HPW_DEV_IDLE;
        end
      endcase
    end
  end

  // stage first half
  // A repeated half drops the staged half and is itself dropped.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_pend_q <= 1'b0;
      wr_half_q <= 1'b0;
      stage_q <= 16'h0000;
      stage_addr_q <= '0;
    end else if (wr_take && !wr_pend_q) begin
      wr_pend_q <= 1'b1;
      wr_half_q <= phys_half;
      stage_q <= bus.wdata;
      stage_addr_q <= bus.dw_addr;
    end else if (push || (wr_take && wr_repeat)) begin
      wr_pend_q <= 1'b0;
    end
  end

  // read pairing state
  // A repeated half clears pairing, so the next read fetches afresh.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_pend_q <= 1'b0;
      rd_half_q <= 1'b0;
      rd_latch_q <= 32'h00000000;
    end else if (state_q == hpw_pkg::HPW_DEV_FETCH && rd_ack_i) begin
      rd_pend_q <= 1'b1;
      rd_half_q <= phys_half;
      rd_latch_q <= rd_data_i;
    end else if (rd_take && rd_pend_q) begin
      rd_pend_q <= 1'b0;
    end
  end

  // Read data returned with the ack
  // On a repeated half the stale latched half is returned; host must re-read.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_q <= 16'h0000;
    end else if (state_q == hpw_pkg::HPW_DEV_FETCH && rd_ack_i) begin
      rdata_q <= fetch_half;
    end else if (rd_take && (rd_pair || rd_repeat)) begin
      rdata_q <= latch_half;
    end
  end

  // Internal read request, held until the read port answers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (rd_take && !rd_pend_q) begin
      rd_req_q <= 1'b1;
      rd_addr_q <= bus.dw_addr;
    end else if (rd_ack_i) begin
      rd_req_q <= 1'b0;
    end
  end

  // commit the doubleword
  // Buffer entries; the staged address is used, the host keeps it steady.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[tail_q] <= {stage_addr_q, commit_word};
    end
  end

  // Buffer pointers and fill count
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        tail_q <= (tail_q == PW'(DEPTH - 1)) ? '0 : tail_q + 1'b1;
      end
      if (pop) begin
        head_q <= (head_q == PW'(DEPTH - 1)) ? '0 : head_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### hpw_host.sv
// Host end of the half-word port: splits doubleword commands into halves.
// Assumes a user that holds a command until cmd_ready_o is seen high.
`timescale 1ns/100ps
`default_nettype none
`include "hpw_cfg.svh"
module hpw_host #(
  parameter int AW = `HPW_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Host bus
  hpw_if.host_mp bus,
  // Copy of the device swap control word
  input wire logic [31:0] swap_ctrl_i,
  // Doubleword command
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [AW-1:0] cmd_addr_i,
  input wire logic [31:0] cmd_data_i,
  output logic cmd_ready_o,
  // Read answer
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o
);

  hpw_pkg::hpw_host_state_t state_q;
  logic cs_q;
  logic we_q;
  logic [AW-1:0] addr_q;
  logic half_q;
  logic [15:0] wdata_q;
  logic [15:0] hi_q;
  logic [15:0] first_q;
  logic rsp_valid_q;
  logic [31:0] rsp_data_q;

  // Bit 1 level that reaches bytes 1:0 under the current swap word
  wire lo_sel = (swap_ctrl_i == `HPW_SWAP_KEY) ? `HPW_HALF_HI : `HPW_HALF_LO;
  wire accept = cmd_valid_i && (state_q == hpw_pkg::HPW_HOST_IDLE);

  assign bus.cs = cs_q;
  assign bus.we = we_q;
  assign bus.dw_addr = addr_q;
  assign bus.half_select_addr = half_q;
  assign bus.wdata = wdata_q;
  assign cmd_ready_o = (state_q == hpw_pkg::HPW_HOST_IDLE);
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;

  // address held
  // The low half always goes first and the second always flips bit 1,
  // so the repeated-half case never arises from this end.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_q <= hpw_pkg::HPW_HOST_IDLE;
      cs_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      half_q <= 1'b0;
      wdata_q <= 16'h0000;
      hi_q <= 16'h0000;
      first_q <= 16'h0000;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 32'h00000000;
    end else begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        hpw_pkg::HPW_HOST_IDLE: begin
          if (accept) begin
            cs_q <= 1'b1;
            we_q <= cmd_write_i;
            addr_q <= cmd_addr_i;
            half_q <= lo_sel;
            wdata_q <= cmd_data_i[15:0];
            hi_q <= cmd_data_i[31:16];
            state_q <= hpw_pkg::HPW_HOST_FIRST;
          end
        end
        hpw_pkg::HPW_HOST_FIRST: begin
          if (bus.ack) begin
            first_q <= bus.rdata;
            half_q <= ~half_q;
            wdata_q <= hi_q;
            state_q <= hpw_pkg::HPW_HOST_SECOND;
          end
        end
        hpw_pkg::HPW_HOST_SECOND: begin
          if (bus.ack) begin
            cs_q <= 1'b0;
            rsp_valid_q <= !we_q;
            rsp_data_q <= {bus.rdata, first_q};
            state_q <= hpw_pkg::HPW_HOST_IDLE;
          end
        end
        default: begin
          state_q <= hpw_pkg::HPW_HOST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### hpw_sva.sv
// Checker for the carrier joining host end and device end of the half-word port.
// Assumes the host end pairs every access and a single core clock.
`timescale 1ns/100ps
`default_nettype none
`include "hpw_cfg.svh"
module hpw_sva #(
  parameter int AW = 8
) (
  // Clock, reset and swap word
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] swap_ctrl_i,
  // Carrier signals
  input wire logic cs,
  input wire logic we,
  input wire logic [AW-1:0] dw_addr,
  input wire logic half_select_addr,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic pair_q;
  logic half_q;
  logic [AW-1:0] addr_q;
  // Decoded swap mode and pending request
  wire swap_on = (swap_ctrl_i == `HPW_SWAP_KEY);
  wire req = cs && !ack;
  // Second half pending after every odd ack
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) pair_q <= 1'b0;
    else if (ack) pair_q <= !pair_q;
  end
  // First half kept without reset: only read once a pair is open
  always_ff @(posedge core_clk_i) begin
    if (ack && !pair_q) begin
      half_q <= half_select_addr;
      addr_q <= dw_addr;
    end
  end
  sequence first_s; req && !pair_q; endsequence
  sequence second_s; req && pair_q; endsequence
  req_hold_a: assert property (req |=> cs && $stable(dw_addr) && $stable(half_select_addr))
    else $error("request changed before ack");
  wr_answer_a: assert property (req && we |-> ##[1:100] ack)
    else $error("write not answered");
  rd_answer_a: assert property (req && !we |-> ##[1:20] ack)
    else $error("read not answered");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  wr_pair_a: assert property (second_s and we |-> half_select_addr != half_q)
    else $error("write pair repeats a half");
  rd_pair_a: assert property (second_s and !we |-> half_select_addr != half_q)
    else $error("read pair repeats a half");
  pair_addr_a: assert property (second_s |-> dw_addr == addr_q)
    else $error("pair crosses doublewords");
  plain_first_a: assert property (first_s and !swap_on |-> half_select_addr == `HPW_HALF_LO)
    else $error("default mode sent wrong half first");
  swap_first_a: assert property (first_s and swap_on |-> half_select_addr == `HPW_HALF_HI)
    else $error("swap mode sent wrong half first");
  rdata_keep_a: assert property (ack && we |-> $stable(rdata))
    else $error("read data moved on a write");
endmodule
`default_nettype wire

// ### host_half_word_port_tb.sv
// Testbench: host end facing device end, plus a second device driven by a faulty host.
// Assumes hpw_cfg.svh, hpw_pkg, hpw_if and both design ends are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "hpw_cfg.svh"
module host_half_word_port_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] swap = 32'h0;
  logic cv = 1'b0;
  logic cw = 1'b0;
  logic [7:0] ca = 8'h00;
  logic [31:0] cd = 32'h0;
  logic wr_ready = 1'b0;
  logic rk = 1'b0;
  logic rk2 = 1'b0;
  logic [31:0] rdv = 32'h0;
  logic cmd_ready, rsp_valid, wr_valid, rq, wv2, rq2;
  logic [31:0] rsp_data, wr_data, wd2, d, fetches = 32'h0;
  logic [7:0] wr_addr, wa2, ra;
  logic [15:0] lo_w, got2;
  logic [31:0] sws [3] = '{32'h0, `HPW_SWAP_KEY, 32'hFFFFFFFF};
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  hpw_if #(.AW(8)) bus ();
  hpw_if #(.AW(8)) bus2 ();
  hpw_host hpw_host_i (.core_clk_i(clk), .nrst_i(nrst), .bus(bus), .swap_ctrl_i(swap),
    .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_data_i(cd),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  hpw_dev hpw_dev_i (.core_clk_i(clk), .nrst_i(nrst), .bus(bus), .swap_ctrl_i(swap),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_ready_i(wr_ready),
    .rd_req_o(rq), .rd_addr_o(ra), .rd_ack_i(rk), .rd_data_i(rdv));
  hpw_dev hpw_dev_x_i (.core_clk_i(clk), .nrst_i(nrst), .bus(bus2), .swap_ctrl_i(32'h0),
    .wr_valid_o(wv2), .wr_addr_o(wa2), .wr_data_o(wd2), .wr_ready_i(1'b0),
    .rd_req_o(rq2), .rd_addr_o(), .rd_ack_i(rk2), .rd_data_i(rdv));
  hpw_sva #(.AW(8)) hpw_sva_i (.core_clk_i(clk), .nrst_i(nrst), .swap_ctrl_i(swap),
    .cs(bus.cs), .we(bus.we), .dw_addr(bus.dw_addr),
    .half_select_addr(bus.half_select_addr), .rdata(bus.rdata), .ack(bus.ack));
  // Clock, 20 ns period
  always #10 clk = !clk;
  // Internal reads answered one cycle after each fetch request
  always @(posedge clk) begin
    rk <= rq && !rk;
    rk2 <= rq2 && !rk2;
    if (rk2) fetches <= fetches + 32'h1;
  end
  // Word carried with select low on the main carrier
  always @(negedge clk) if (bus.cs && bus.we && !bus.half_select_addr) lo_w = bus.wdata;
  // Hang guard well past the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task cmd(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= v;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cv <= 1'b0;
  endtask
  task rd_chk(input logic [31:0] v);
    @(posedge clk);
    rdv <= v;
    cmd(1'b0, 8'h22, 32'h0);
    while (rsp_valid !== 1'b1) @(negedge clk);
    chk("rsp_data", v, rsp_data);
    chk("rd_addr", 32'h22, {24'h0, ra});
  endtask
  task pop(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    while (wr_valid !== 1'b1) @(negedge clk);
    chk("wr_addr", {24'h0, a}, {24'h0, wr_addr});
    chk("wr_data", v, wr_data);
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
  endtask
  // Faulty host on the second carrier; wdata goes stale-inverted on release
  task bw(input logic w, input logic h, input logic [15:0] v);
    @(posedge clk);
    bus2.cs <= 1'b1;
    bus2.we <= w;
    bus2.half_select_addr <= h;
    bus2.wdata <= v;
    @(negedge clk);
    while (bus2.ack !== 1'b1) @(negedge clk);
    got2 = bus2.rdata;
    @(posedge clk);
    bus2.cs <= 1'b0;
    bus2.wdata <= ~v;
  endtask
  task summarize();
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    bus2.cs = 1'b0;
    bus2.we = 1'b0;
    bus2.dw_addr = 8'h3C;
    bus2.half_select_addr = 1'b0;
    bus2.wdata = 16'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Default, swap key, and an all-ones word that is not the key
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      swap <= sws[i];
      d = 32'hA1B2_C3D4 + i;
      cmd(1'b1, 8'h21, d);
      pop(8'h21, d);
      chk("bus_low", {16'h0, (i == 1) ? d[31:16] : d[15:0]}, {16'h0, lo_w});
      rd_chk(~d);
      $display("Test mapping %0d done", i);
    end
    // Drain stalled: third pair must wait on its second half
    for (int i = 0; i < 3; i++) cmd(1'b1, 8'(64 + i), 32'h1111_0000 + i);
    repeat (10) @(negedge clk);
    chk("stalled_cs", 32'h1, {31'h0, bus.cs});
    for (int i = 0; i < 3; i++) pop(8'(64 + i), 32'h1111_0000 + i);
    repeat (4) @(negedge clk);
    chk("wr_valid", 32'h0, {31'h0, wr_valid});
    $display("Test buffer done");
    // Repeated write half drops both; a later high-first pair commits
    bw(1'b1, 1'b0, 16'h1234);
    bw(1'b1, 1'b0, 16'h5678);
    bw(1'b1, 1'b1, 16'hBEEF);
    repeat (4) @(negedge clk);
    chk("wv2", 32'h0, {31'h0, wv2});
    bw(1'b1, 1'b0, 16'hCAFE);
    repeat (2) @(negedge clk);
    chk("wd2", 32'hBEEF_CAFE, wd2);
    chk("wa2", 32'h3C, {24'h0, wa2});
    $display("Test repeated write done");
    // Repeated read half clears pairing; next read fetches afresh
    @(posedge clk);
    rdv <= 32'h9ABC_DEF0;
    bw(1'b0, 1'b0, 16'h0);
    chk("got2", 32'hDEF0, {16'h0, got2});
    bw(1'b0, 1'b0, 16'h0);
    bw(1'b0, 1'b1, 16'h0);
    chk("fetches", 32'h2, fetches);
    chk("got2", 32'h9ABC, {16'h0, got2});
    bw(1'b0, 1'b0, 16'h0);
    chk("fetches", 32'h2, fetches);
    chk("got2", 32'hDEF0, {16'h0, got2});
    $display("Test repeated read done");
    summarize();
  end
endmodule
`default_nettype wire
